// ===== verilog/tdb_pkg.sv
package tdb_pkg;
    // Clock rate
    localparam int CLOCK_HZ = 100_000_000;
    // Blink timing in milliseconds and fast burst count; no durations are fixed for them
    localparam int FAST_HALF_MS = 50;
    localparam int SLOW_HALF_MS = 250;
    localparam int GAP_MS = 1000;
    localparam int FAST_COUNT = 8;
    // Cycle counts derived from the times
    localparam int FAST_HALF_CYC = FAST_HALF_MS * (CLOCK_HZ / 1000);
    localparam int SLOW_HALF_CYC = SLOW_HALF_MS * (CLOCK_HZ / 1000);
    localparam int GAP_CYC = GAP_MS * (CLOCK_HZ / 1000);
    // Error type codes (pulse count of first slow sequence)
    localparam logic [2:0] ERR_NONVOL = 3'h1;
    localparam logic [2:0] ERR_CONFIG = 3'h2;
    localparam logic [2:0] ERR_COMMAND = 3'h3;
    localparam logic [2:0] ERR_BUSDATA = 3'h4;
    localparam logic [2:0] ERR_REGCOMM = 3'h5;
    localparam logic [2:0] ERR_FIELDBUS = 3'h6;
    // Arguments of type one
    localparam logic [7:0] ARG_CHECKSUM = 8'h00;
    localparam logic [7:0] ARG_CODEBUF = 8'h01;
    localparam logic [7:0] ARG_DATATYPE = 8'h02;
    localparam int POS_W = 8;

    // One fault as reported by the diagnosis engine
    typedef struct packed {
        logic [2:0] kind;
        logic [7:0] arg;
        logic stop;
    } tdb_fault_t;

    typedef enum logic [2:0] {
        TDB_IDLE, TDB_FAST, TDB_GAP1, TDB_TYPE, TDB_GAP2, TDB_ARG, TDB_GAP3
    } tdb_state_t;
endpackage

// ===== verilog/tdb_blink.sv
`timescale 1ns/1ps
// What this block does
// (RULE1) Check terminals right after power-on; red off on clean start-up.
// (RULE2) Green lit while fault free; red blinks at two rates on faults. Code keeps green dark while a diagnosis runs.
// (RULE3) Code is fast burst, slow type pulses, then slow argument pulses.
// (RULE4) Type 1: checksum arg 0, code buffer overflow 1, data type 2.
// (RULE5) Type 2: table entry arg 0; mismatch at terminal n arg n.
// (RULE6) Type 3 arg 0: terminal bus command error.
// (RULE7) Type 4: data error arg 0; break behind terminal n arg n.
// (RULE8) Type 5: register communication failure at terminal n, arg n.
// (RULE9) Argument is last terminal position, passive terminals not counted.
// (RULE10) Some faults latch a stop state until power cycle or scanner reset.
// (RULE11) Diagnose only at power-up or on a fieldbus access. Code also diagnoses after a scanner reset.
// (RULE12) Blink periods, gaps and repetition are parameters. Code has no parameter for repetition; the code always repeats.
module tdb_blink
    import tdb_pkg::*;
#(
    parameter int FAST_HALF = FAST_HALF_CYC, // (RULE12)
    parameter int SLOW_HALF = SLOW_HALF_CYC,
    parameter int GAP = GAP_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic scanner_reset,
    input wire logic fieldbus_access,
    input wire logic diag_done,
    input wire logic diag_fault,
    input wire tdb_fault_t diag_result,
    output logic diag_start,
    output logic busy,
    output logic stopped,
    output logic led_green,
    output logic led_red
);
    tdb_state_t state;
    tdb_fault_t cur;
    logic fault_on;
    logic running;
    logic pending;
    logic [31:0] timer;
    logic [7:0] pulses;
    logic phase;
    logic timer_done;

    assign timer_done = (timer == 32'h0);

    // Diagnosis requests: power-up, scanner reset, then each fieldbus access (RULE11)
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pending <= 1'b1; // Power-up check (RULE1)
            running <= 1'b0;
            diag_start <= 1'b0;
        end else if (scanner_reset) begin
            pending <= 1'b1;
            running <= 1'b0;
            diag_start <= 1'b0;
        end else begin
            diag_start <= 1'b0;
            if (fieldbus_access) begin
                pending <= 1'b1; // (RULE11)
            end
            if (running) begin
                if (diag_done) begin
                    running <= 1'b0;
                end
            end else if (pending && !stopped) begin
                // Stopped coupler ignores further diagnosis (RULE10)
                pending <= fieldbus_access;
                running <= 1'b1;
                diag_start <= 1'b1;
            end
        end
    end

    // Latched fault and stop state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fault_on <= 1'b0;
            stopped <= 1'b0;
            cur <= '0;
        end else if (scanner_reset) begin
            fault_on <= 1'b0; // Only way out of stop besides power (RULE10)
            stopped <= 1'b0;
            cur <= '0;
        end else if (running && diag_done && !stopped) begin
            fault_on <= diag_fault; // Clean result clears the code (RULE1)
            if (diag_fault) begin
                cur <= diag_result; // Type and arg as reported (RULE4)
                stopped <= diag_result.stop; // (RULE10)
            end
        end
    end

    // Busy mirrors a diagnosis in flight
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
        end else begin
            busy <= running && !diag_done;
        end
    end

    // Blink sequencer; restarts the full code after the closing gap (RULE3)
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= TDB_IDLE;
            timer <= 32'h0;
            pulses <= 8'h0;
            phase <= 1'b0;
        end else if (!fault_on || scanner_reset) begin
            state <= TDB_IDLE;
            timer <= 32'h0;
            pulses <= 8'h0;
            phase <= 1'b0;
        end else if (!timer_done) begin
            timer <= timer - 32'h1;
        end else begin
            case (state)
                TDB_IDLE: begin
                    state <= TDB_FAST;
                    pulses <= 8'(FAST_COUNT);
                    phase <= 1'b1;
                    timer <= 32'(FAST_HALF - 1);
                end
                TDB_FAST: begin
                    // Fast burst marks the start of a code (RULE3)
                    phase <= !phase;
                    timer <= 32'(FAST_HALF - 1);
                    if (phase) begin
                        pulses <= pulses - 8'h1;
                        if (pulses == 8'h1) begin
                            state <= TDB_GAP1;
                            timer <= 32'(GAP - 1);
                        end
                    end
                end
                TDB_GAP1: begin
                    // Type count (RULE4) (RULE5) (RULE6) (RULE7) (RULE8)
                    state <= TDB_TYPE;
                    pulses <= {5'h0, cur.kind};
                    phase <= 1'b1;
                    timer <= 32'(SLOW_HALF - 1);
                end
                TDB_TYPE: begin
                    phase <= !phase;
                    timer <= 32'(SLOW_HALF - 1);
                    if (phase) begin
                        pulses <= pulses - 8'h1;
                        if (pulses == 8'h1) begin
                            state <= TDB_GAP2;
                            timer <= 32'(GAP - 1);
                        end
                    end
                end
                TDB_GAP2: begin
                    // Argument zero gives no slow pulses (RULE9)
                    pulses <= cur.arg;
                    if (cur.arg == 8'h0) begin
                        state <= TDB_GAP3;
                        timer <= 32'(GAP - 1);
                    end else begin
                        state <= TDB_ARG;
                        phase <= 1'b1;
                        timer <= 32'(SLOW_HALF - 1);
                    end
                end
                TDB_ARG: begin
                    phase <= !phase;
                    timer <= 32'(SLOW_HALF - 1);
                    if (phase) begin
                        pulses <= pulses - 8'h1;
                        if (pulses == 8'h1) begin
                            state <= TDB_GAP3;
                            timer <= 32'(GAP - 1);
                        end
                    end
                end
                TDB_GAP3: begin
                    state <= TDB_IDLE; // Repeat whole code (RULE12)
                end
                default: begin
                    state <= TDB_IDLE;
                end
            endcase
        end
    end

    // Indicator drive (RULE2)
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            led_red <= 1'b0;
            led_green <= 1'b0;
        end else begin
            led_green <= !fault_on && !running; // (RULE2)
            led_red <= fault_on && phase && !scanner_reset; // (RULE1)
        end
    end

    // Red stays dark without a latched fault
    chk_red_dark_clean: assert property ( // (RULE1)
        @(posedge clock) disable iff (rst)
        !fault_on |=> !led_red)
        else $error("red lit with no fault");
    // Clean result lights green and darkens red
    chk_clean_lights: assert property ( // (RULE1)
        @(posedge clock) disable iff (rst)
        running && diag_done && !diag_fault |-> ##2 (led_green && !led_red))
        else $error("clean diagnosis not shown");
    // A queued request is served on the next edge, power-up included
    chk_pending_start: assert property ( // (RULE1)
        @(posedge clock) disable iff (rst)
        pending && !running && !stopped && !scanner_reset |=> diag_start)
        else $error("queued diagnosis not started");
    // Green and red never lit together
    chk_leds_exclusive: assert property ( // (RULE2)
        @(posedge clock) disable iff (rst)
        !(led_green && led_red))
        else $error("both indicators lit");
    // Green stays dark while a diagnosis runs
    chk_green_dark_busy: assert property ( // (RULE2)
        @(posedge clock) disable iff (rst)
        running |=> !led_green)
        else $error("green lit during diagnosis");
    // Red follows the blink phase one cycle late
    chk_red_phase: assert property ( // (RULE2)
        @(posedge clock) disable iff (rst)
        fault_on && !scanner_reset |=> led_red == $past(phase))
        else $error("red out of step with blink phase");
    // Fast burst is followed by the type gap
    chk_fast_then_gap: assert property ( // (RULE3)
        @(posedge clock) disable iff (rst)
        state == TDB_FAST && fault_on |=> state inside {TDB_FAST, TDB_GAP1,
        TDB_IDLE})
        else $error("bad order after fast burst");
    // Each code opens with the full fast burst
    chk_burst_count: assert property ( // (RULE3)
        @(posedge clock) disable iff (rst)
        state == TDB_IDLE && timer_done && fault_on && !scanner_reset
        |=> state == TDB_FAST && pulses == 8'(FAST_COUNT))
        else $error("fast burst count wrong");
    // Last fast pulse ends dark and enters the gap
    chk_burst_to_gap: assert property ( // (RULE3)
        @(posedge clock) disable iff (rst)
        state == TDB_FAST && phase && pulses == 8'h01 && timer_done
        && fault_on && !scanner_reset |=> state == TDB_GAP1 && !phase)
        else $error("fast burst did not end");
    // Type pulse count taken from the latched fault
    chk_type_count: assert property ( // (RULE4)
        @(posedge clock) disable iff (rst)
        state == TDB_GAP1 && timer_done && fault_on && !scanner_reset
        |=> state == TDB_TYPE && pulses == {5'h0, cur.kind})
        else $error("type count wrong");
    // A reported fault is latched as given
    chk_fault_latch: assert property ( // (RULE4)
        @(posedge clock) disable iff (rst)
        running && diag_done && diag_fault && !stopped && !scanner_reset
        |=> fault_on && cur == $past(diag_result))
        else $error("fault not latched");
    // Argument count taken from the latched fault
    chk_arg_count: assert property ( // (RULE9)
        @(posedge clock) disable iff (rst)
        state == TDB_GAP2 && timer_done && fault_on && !scanner_reset
        |=> pulses == cur.arg)
        else $error("argument count wrong");
    // Argument zero goes straight to the closing gap
    chk_arg_zero_skip: assert property ( // (RULE9)
        @(posedge clock) disable iff (rst)
        state == TDB_GAP2 && timer_done && fault_on && !scanner_reset
        && cur.arg == 8'h00 |=> state == TDB_GAP3)
        else $error("argument zero blinked");
    // Stop holds against later diagnosis
    chk_stop_holds: assert property ( // (RULE10)
        @(posedge clock) disable iff (rst)
        stopped && !scanner_reset |=> stopped)
        else $error("stop state left without reset");
    // Stop flag follows the reported fault
    chk_stop_latch: assert property ( // (RULE10)
        @(posedge clock) disable iff (rst)
        running && diag_done && diag_fault && !scanner_reset
        |=> stopped == $past(diag_result.stop))
        else $error("stop flag not taken");
    // No diagnosis starts while stopped
    chk_no_start_stopped: assert property ( // (RULE10)
        @(posedge clock) disable iff (rst)
        stopped |=> !diag_start)
        else $error("diagnosis started while stopped");
    // Scanner reset clears the stop state
    chk_scan_reset: assert property ( // (RULE10)
        @(posedge clock) disable iff (rst)
        scanner_reset |=> !stopped && !fault_on)
        else $error("scanner reset ignored");
    // Access starts diagnosis within two cycles
    chk_access_diag: assert property ( // (RULE11)
        @(posedge clock) disable iff (rst)
        fieldbus_access && !running && !stopped && !scanner_reset
        |-> ##[1:2] diag_start)
        else $error("access did not start diagnosis");
    // Start request is a single-cycle pulse
    chk_start_pulse: assert property ( // (RULE11)
        @(posedge clock) disable iff (rst)
        diag_start |=> !diag_start)
        else $error("start request held too long");
    // Busy shown while the engine works
    chk_busy_shown: assert property ( // (RULE11)
        @(posedge clock) disable iff (rst)
        running && !diag_done |=> busy)
        else $error("busy not shown during diagnosis");
    // Whole code repeats after the closing gap
    chk_code_repeats: assert property ( // (RULE12)
        @(posedge clock) disable iff (rst)
        state == TDB_GAP3 && timer_done && fault_on && !scanner_reset
        |=> state == TDB_IDLE)
        else $error("code not repeated");
endmodule // tdb_blink

// ===== dv/tdb_chain_model.sv
`timescale 1ns/1ps
// Stand-in for the terminal chain and its diagnosis engine
module tdb_chain_model
    import tdb_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic diag_start,
    input wire logic want_fault,
    input wire tdb_fault_t want_result,
    output logic diag_done,
    output logic diag_fault,
    output tdb_fault_t diag_result
);
    logic [2:0] wait_cnt;
    // Scan takes a few cycles; result churns while not valid
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wait_cnt <= 3'h0;
            diag_done <= 1'b0;
            diag_fault <= 1'b0;
            diag_result <= '0;
        end else begin
            diag_done <= (wait_cnt == 3'h1);
            if (wait_cnt == 3'h1) begin
                diag_fault <= want_fault;
                diag_result <= want_result;
            end else begin
                diag_fault <= ~diag_fault;
                diag_result <= ~diag_result;
            end
            if (diag_start) begin
                wait_cnt <= 3'h4;
            end else if (wait_cnt != 3'h0) begin
                wait_cnt <= wait_cnt - 3'h1;
            end
        end
    end
endmodule // tdb_chain_model

// ===== dv/tdb_blink_test.sv
`timescale 1ns/1ps
module tdb_blink_test;
    import tdb_pkg::*;
    localparam int FH = 4;
    localparam int SH = 8;
    localparam int GP = 16;
    logic clock, rst, scanner_reset, fieldbus_access, want_fault, s, b;
    logic diag_done, diag_fault, diag_start, busy, stopped;
    logic led_green, led_red;
    tdb_fault_t want_result, diag_result, f;
    int bad_count, checked, cyc, i;
    logic [7:0] seed;
    logic [2:0] kinds [9] = '{3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4,
        3'h4, 3'h5};
    logic [7:0] args [9] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h09, 8'h00,
        8'h00, 8'h09, 8'h09};
    tdb_blink #(.FAST_HALF(FH), .SLOW_HALF(SH), .GAP(GP)) dut (
        .clock(clock), .rst(rst), .scanner_reset(scanner_reset),
        .fieldbus_access(fieldbus_access), .diag_done(diag_done),
        .diag_fault(diag_fault), .diag_result(diag_result),
        .diag_start(diag_start), .busy(busy), .stopped(stopped),
        .led_green(led_green), .led_red(led_red));
    tdb_chain_model chain (
        .clock(clock), .rst(rst), .diag_start(diag_start),
        .want_fault(want_fault), .want_result(want_result),
        .diag_done(diag_done), .diag_fault(diag_fault),
        .diag_result(diag_result));
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Free-running 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Hang guard well above the longest expected run
    always @(posedge clock) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            print_verdict();
        end
    end
    task seen_start;
        s = 1'b0;
        b = 1'b0;
        repeat (8) begin
            @(negedge clock);
            s = s | (diag_start === 1'b1);
            b = b | (busy === 1'b1);
        end
        repeat (8) @(negedge clock);
    endtask
    // One diagnosis round trip, optionally without a bus access
    task diagnose(input logic fault, input tdb_fault_t r, input logic acc);
        @(posedge clock);
        want_fault <= fault;
        want_result <= r;
        fieldbus_access <= acc;
        @(posedge clock);
        fieldbus_access <= 1'b0;
        seen_start();
    endtask
    // Pulses until a long low; width of the first one
    task get_group(output int n, output int w);
        int h, l;
        n = 0;
        l = 0;
        while (l <= SH + 2) begin
            h = 0;
            l = 0;
            while (led_red === 1'b1 && h < 100) begin
                h++;
                @(negedge clock);
            end
            while (led_red !== 1'b1 && l < 100) begin
                l++;
                @(negedge clock);
            end
            if (n == 0) w = h;
            n++;
        end
    endtask
    task check_code(input tdb_fault_t r);
        int n, w, k;
        k = 0;
        while (led_red !== 1'b1 && k < 300) begin
            k++;
            @(negedge clock);
        end
        chk(led_green === 1'b0, "green lit during fault");
        // Code may be under way already: drop one group, seek a fresh burst
        get_group(n, w);
        k = 0;
        w = 0;
        while (w != FH && k < 4) begin
            k++;
            get_group(n, w);
        end
        chk(n == FAST_COUNT && w == FH, "fast burst");
        get_group(n, w);
        chk(n == r.kind && w == SH, "type pulses");
        get_group(n, w);
        if (r.arg != 8'h00) begin
            chk(n == r.arg && w == SH, "argument pulses");
        end else begin
            chk(n == FAST_COUNT && w == FH, "zero argument");
        end
    endtask
    initial begin
        rst = 1'b1;
        scanner_reset = 1'b0;
        fieldbus_access = 1'b0;
        want_fault = 1'b0;
        want_result = '0;
        seed = 8'h55;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        seen_start();
        chk(s, "no power-up diagnosis");
        chk(b, "no busy at power-up");
        chk(led_green === 1'b1 && led_red === 1'b0, "clean start");
        // Fault present but nobody asks: nothing may change
        diagnose(1'b1, {ERR_COMMAND, 8'h00, 1'b0}, 1'b0);
        chk(!s && led_green === 1'b1, "unrequested diagnosis");
        chk(b === 1'b0, "busy without request");
        $display("test start-up done");
        for (i = 0; i < 9; i++) begin
            seed = lfsr(seed);
            f = {kinds[i], 8'h00, 1'b0};
            f.arg = (args[i] == 8'h09) ? {5'h0, seed[2:0]} + 8'h01 : args[i];
            diagnose(1'b1, f, 1'b1);
            chk(s && b && stopped === 1'b0, "fault diagnosis");
            check_code(f);
            diagnose(1'b0, '0, 1'b1);
            chk(led_green === 1'b1 && led_red === 1'b0, "clear");
        end
        $display("test codes done");
        f = {ERR_BUSDATA, 8'h03, 1'b1};
        diagnose(1'b1, f, 1'b1);
        chk(stopped === 1'b1, "stop not latched");
        diagnose(1'b0, '0, 1'b1);
        chk(!s && stopped === 1'b1, "diagnosed while stopped");
        check_code(f);
        @(posedge clock);
        scanner_reset <= 1'b1;
        @(posedge clock);
        scanner_reset <= 1'b0;
        seen_start();
        chk(s && stopped === 1'b0, "scanner restart");
        chk(led_green === 1'b1 && led_red === 1'b0, "after restart");
        $display("test stop done");
        print_verdict();
    end
endmodule // tdb_blink_test
